// ===== common/sdcr_pkg.sv
package sdcr_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, low address bits only)
  // ---------------------------------------------------------------
  localparam int          ADDR_W              = 12;
  localparam int          WORD_W              = 32;
  localparam logic [11:0] BLOCK_CONFIG_OFS    = 12'h204;
  localparam logic [11:0] XFER_STATUS_OFS     = 12'h208;
  localparam logic [11:0] COMMAND_CONTROL_OFS = 12'h20C;
  localparam logic [11:0] RESP_WORD0_OFS      = 12'h210;
  localparam logic [11:0] RESP_WORD1_OFS      = 12'h214;
  localparam logic [11:0] RESP_WORD2_OFS      = 12'h218;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DMA_BIT       = 0;
  localparam int BCE_BIT       = 1;
  localparam int DIR_BIT       = 4;
  localparam int MULTI_BLOCK_SELECT_BIT      = 5;
  localparam int RTYPE_LSB     = 16;
  localparam int BLK_CNT_LSB   = 16;
  localparam int BLK_CNT_W     = 16;
  localparam int STAT_ACT_BIT  = 0;
  localparam int STAT_OPEN_BIT = 1;
  localparam int STAT_CNT_LSB  = 16;
  localparam int RESP_W        = 128;
  localparam int RESP_WORDS    = 3;
  localparam int SHORT_LSB     = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [31:0] RESP_RESET = 32'h0000_0000;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic        DIR_WRITE  = 1'b0;
  localparam logic        DIR_READ   = 1'b1;
  typedef enum logic [1:0] {
    RESP_NONE         = 2'b00,
    RESP_LONG136      = 2'b01,
    RESP_SHORT48      = 2'b10,
    RESP_SHORT48_BUSY = 2'b11
  } sdcr_resp_type_t;
endpackage

// ===== src/sdcr_ahb_slave.sv
`timescale 1ns/100ps
module sdcr_ahb_slave (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic                           hready,
  input  wire logic [31:0]                    hwdata,
  input  wire logic [31:0]                    rdData,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic [31:0]                         hrdata,
  output logic                                accWr,
  output logic                                accRd,
  output logic [sdcr_pkg::ADDR_W-1:0]         accAddr,
  output logic [31:0]                         accWdata
);
  import sdcr_pkg::*;
  typedef enum logic {SL_IDLE = 1'b0, SL_WAIT = 1'b1} sdcr_sl_state_t;
  typedef struct packed {
    sdcr_sl_state_t      st;
    logic [ADDR_W-1:0]   addr;
    logic                write;
    logic                word;
    logic                ready;
    logic [31:0]         rdata;
  } sdcr_sl_t;
  localparam sdcr_sl_t SL_RESET = '{SL_IDLE, '0, 1'b0, 1'b0, 1'b1, RESP_RESET};
  sdcr_sl_t state_reg;
  sdcr_sl_t state_next;
  // one wait state so that read data leaves a flip-flop
  always_comb begin
    state_next = state_reg;
    accWr      = 1'b0;
    accRd      = 1'b0;
    case (state_reg.st)
      SL_IDLE: if (hsel && htrans[1] && hready) begin
        state_next.st    = SL_WAIT;
        state_next.addr  = haddr[ADDR_W-1:0];
        state_next.write = hwrite;
        state_next.word  = (hsize == HSIZE_WORD);
        state_next.ready = 1'b0;
      end
      SL_WAIT: begin
        accWr            = state_reg.write && state_reg.word;
        accRd            = !state_reg.write;
        state_next.rdata = state_reg.write ? state_reg.rdata : rdData;
        state_next.ready = 1'b1;
        state_next.st    = SL_IDLE;
      end
      default: state_next = SL_RESET;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_reg <= SL_RESET;
    else     state_reg <= state_next;
  end
  assign hreadyout = state_reg.ready;
  assign hresp     = 1'b0;
  assign hrdata    = state_reg.rdata;
  assign accAddr   = state_reg.addr;
  assign accWdata  = hwdata;
endmodule // sdcr_ahb_slave

// ===== src/sdcr_xfer_ctrl.sv
`timescale 1ns/100ps
module sdcr_xfer_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             blockDone,
  input  wire logic             stop,
  input  wire logic             multiBlock,
  input  wire logic             countEnable,
  input  wire logic [CNT_W-1:0] blockCount,
  output logic                  active,
  output logic                  openEnded,
  output logic [CNT_W-1:0]      count,
  output logic                  done
);
  import sdcr_pkg::*;
  typedef struct packed {
    logic             active;
    logic             openEnd;
    logic [CNT_W-1:0] count;
    logic             done;
  } sdcr_xf_t;
  localparam sdcr_xf_t XF_RESET = '{1'b0, 1'b0, '0, 1'b0};
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
  sdcr_xf_t state_reg;
  sdcr_xf_t state_next;
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (state_reg.active) begin
      if (stop) begin
        state_next.active = 1'b0;
        state_next.done   = 1'b1;
      end else if (blockDone) begin
        // open-ended runs count blocks up and never stop by themselves
        // open-ended keeps going
        if (state_reg.openEnd) begin
          state_next.count = state_reg.count + ONE;
        end else begin
          state_next.count = state_reg.count - ONE;
          if (state_reg.count == ONE) begin
            state_next.active = 1'b0;
            state_next.done   = 1'b1;
          end
        end
      end
    end else if (start) begin
      state_next.openEnd = multiBlock && !countEnable;
      if (state_next.openEnd) state_next.count = '0;
      else if (multiBlock)    state_next.count = blockCount;
      else                    state_next.count = ONE;
      // a bounded run of zero blocks ends at once
      state_next.active = state_next.openEnd || (state_next.count != '0);
      state_next.done   = !state_next.active;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_reg <= XF_RESET;
    else     state_reg <= state_next;
  end
  assign active    = state_reg.active;
  assign openEnded = state_reg.openEnd;
  assign count     = state_reg.count;
  assign done      = state_reg.done;
endmodule // sdcr_xfer_ctrl

// ===== src/sdcr_cmd_resp_regs.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
// Behaviour
// - direction bit: 0 write, 1 read
// - count enable uses block count bits 31:16
// - count disabled multi-block runs open-ended
// - count enabled multi-block ends after count
// - command bit 0 enables DMA mode
// - short response: word0 holds bits 39:8
// - long response: word0 holds bits 31:0
// - long response: word1 holds bits 63:32
// - long response: word2 holds bits 95:64
// - response words read-only, zero after reset
// - response type codes none, 136, 48, busy
module sdcr_cmd_resp_regs #(
  parameter int CNT_W = sdcr_pkg::BLK_CNT_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      respDone,
  input  wire logic [sdcr_pkg::RESP_W-1:0] respBits,
  input  wire logic                      xferStart,
  input  wire logic                      blockDone,
  input  wire logic                      xferStop,
  output logic                           cmdIssue,
  output sdcr_pkg::sdcr_resp_type_t      responseType,
  output logic                           transferDirection,
  output logic                           dmaModeEnable,
  output logic                           multiBlockSelect,
  output logic                           blockCountEnable,
  output logic [CNT_W-1:0]               blockCount,
  output logic                           xferActive,
  output logic                           xferEnd
);
  import sdcr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                            dir;
    logic                            bce;
    logic                            dma;
    logic                            multi_block_select;
    sdcr_resp_type_t                 rtype;
    logic [CNT_W-1:0]                blkCnt;
    logic [RESP_WORDS-1:0][WORD_W-1:0] respWord;
    logic                            issue;
  } sdcr_regs_t;

  localparam sdcr_regs_t REGS_RESET = '{
    dir:      DIR_WRITE,
    bce:      1'b0,
    dma:      1'b0,
    multi_block_select:     1'b0,
    rtype:    RESP_NONE,
    blkCnt:   CNT_RESET,
    respWord: '0,
    issue:    1'b0
  };

  sdcr_regs_t        state_reg;
  sdcr_regs_t        state_next;
  logic              accWr;
  logic              accRd;
  logic [ADDR_W-1:0] accAddr;
  logic [31:0]       accWdata;
  logic [31:0]       rdData;
  logic              xferOpen;
  logic [CNT_W-1:0]  xferCount;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  sdcr_ahb_slave u_slave (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .rdData    (rdData),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .accWr     (accWr),
    .accRd     (),
    .accAddr   (accAddr),
    .accWdata  (accWdata)
  );

  // ---------------------------------------------------------------
  // transfer sequencing
  // ---------------------------------------------------------------
  // relied on: multi_block_select low means exactly one block
  sdcr_xfer_ctrl #(
    .CNT_W (CNT_W)
  ) u_xfer (
    .clk         (clk),
    .rst         (rst),
    .start       (xferStart),
    .blockDone   (blockDone),
    .stop        (xferStop),
    .multiBlock  (state_reg.multi_block_select),
    .countEnable (state_reg.bce),
    .blockCount  (state_reg.blkCnt),
    .active      (xferActive),
    .openEnded   (xferOpen),
    .count       (xferCount),
    .done        (xferEnd)
  );

  // ---------------------------------------------------------------
  // register writes and response capture
  // ---------------------------------------------------------------
  always_comb begin
    state_next       = state_reg;
    state_next.issue = 1'b0;
    if (accWr) begin
      case (accAddr)
        COMMAND_CONTROL_OFS: begin
          state_next.dir   = accWdata[DIR_BIT];
          state_next.bce   = accWdata[BCE_BIT];
          state_next.dma   = accWdata[DMA_BIT];
          state_next.multi_block_select  = accWdata[MULTI_BLOCK_SELECT_BIT];
          state_next.rtype = sdcr_resp_type_t'(accWdata[RTYPE_LSB +: 2]);
          // writing the command word launches the command
          state_next.issue = 1'b1;
        end
        BLOCK_CONFIG_OFS: begin
          state_next.blkCnt = accWdata[BLK_CNT_LSB +: CNT_W];
        end
        default: ;
      endcase
    end
    // load once the response is complete
    if (respDone) begin
      case (state_reg.rtype)
        RESP_LONG136: begin
          for (int i = 0; i < RESP_WORDS; i++) begin
            state_next.respWord[i] = respBits[i*WORD_W +: WORD_W];
          end
        end
        RESP_SHORT48, RESP_SHORT48_BUSY: begin
          state_next.respWord[0] = respBits[SHORT_LSB +: WORD_W];
        end
        // no response expected: keep the old words
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdData = '0;
    case (accAddr)
      COMMAND_CONTROL_OFS: begin
        rdData[DIR_BIT]          = state_reg.dir;
        rdData[BCE_BIT]          = state_reg.bce;
        rdData[DMA_BIT]          = state_reg.dma;
        rdData[MULTI_BLOCK_SELECT_BIT]         = state_reg.multi_block_select;
        rdData[RTYPE_LSB +: 2]   = state_reg.rtype;
      end
      BLOCK_CONFIG_OFS: rdData[BLK_CNT_LSB +: CNT_W] = state_reg.blkCnt;
      XFER_STATUS_OFS: begin
        rdData[STAT_ACT_BIT]            = xferActive;
        rdData[STAT_OPEN_BIT]           = xferOpen;
        rdData[STAT_CNT_LSB +: CNT_W]   = xferCount;
      end
      RESP_WORD0_OFS: rdData = state_reg.respWord[0];
      RESP_WORD1_OFS: rdData = state_reg.respWord[1];
      RESP_WORD2_OFS: rdData = state_reg.respWord[2];
      // unmapped addresses read zero with an OKAY answer
      default: rdData = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_reg <= REGS_RESET;
    else     state_reg <= state_next;
  end

  assign cmdIssue          = state_reg.issue;
  assign responseType      = state_reg.rtype;
  assign transferDirection = state_reg.dir;
  assign dmaModeEnable     = state_reg.dma;
  assign multiBlockSelect  = state_reg.multi_block_select;
  assign blockCountEnable  = state_reg.bce;
  assign blockCount        = state_reg.blkCnt;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic cmdWrite;
  logic respWrite;
  assign cmdWrite  = accWr && (accAddr == COMMAND_CONTROL_OFS);
  assign respWrite = accWr && !respDone &&
                     ((accAddr == RESP_WORD0_OFS) ||
                      (accAddr == RESP_WORD1_OFS) ||
                      (accAddr == RESP_WORD2_OFS));

  dir_follows_write_a: assert property (
    cmdWrite |=> (transferDirection == $past(accWdata[DIR_BIT]))
             ##1 (transferDirection == $past(accWdata[DIR_BIT], 2)) || accWr
  ) else $error("direction bit did not follow the command write");

  // the start edge used the fields as they stood one cycle earlier
  count_loaded_a: assert property (
    ($rose(xferActive) && $past(multiBlockSelect) && $past(blockCountEnable))
      |-> (xferCount == $past(blockCount)) && !xferOpen
  ) else $error("bounded transfer did not take the block count");

  blkcnt_follows_a: assert property (
    (accWr && (accAddr == BLOCK_CONFIG_OFS))
      |=> blockCount == $past(accWdata[BLK_CNT_LSB +: CNT_W])
  ) else $error("block count did not follow the block write");

  open_never_ends_a: assert property (
    (xferActive && xferOpen && !xferStop) [*2] |=> !xferEnd
  ) else $error("open-ended transfer ended without a stop");

  open_start_a: assert property (
    ($rose(xferActive) && $past(multiBlockSelect) && !$past(blockCountEnable))
      |-> xferOpen && (xferCount == '0)
  ) else $error("open-ended transfer did not start from zero");

  bounded_end_a: assert property (
    (xferActive && !xferOpen && blockDone && !xferStop &&
     xferCount == CNT_W'(1))
      |=> xferEnd && !xferActive
          ##1 (!xferEnd || $past(xferStart))
  ) else $error("bounded transfer did not end after its last block");

  dma_follows_write_a: assert property (
    cmdWrite |=> (dmaModeEnable == $past(accWdata[DMA_BIT])) && cmdIssue
  ) else $error("dma enable did not follow the command write");

  short_resp_map_a: assert property (
    (respDone && (responseType == RESP_SHORT48 ||
                  responseType == RESP_SHORT48_BUSY))
      |=> (state_reg.respWord[0] == $past(respBits[SHORT_LSB +: WORD_W]))
          && $stable(state_reg.respWord[2])
  ) else $error("short response mapped wrongly");

  long_word0_a: assert property (
    (respDone && responseType == RESP_LONG136)
      |=> state_reg.respWord[0] == $past(respBits[WORD_W-1:0])
  ) else $error("long response low word mapped wrongly");

  long_word1_a: assert property (
    (respDone && responseType == RESP_LONG136)
      |=> state_reg.respWord[1] == $past(respBits[2*WORD_W-1:WORD_W])
  ) else $error("long response middle word mapped wrongly");

  long_word2_a: assert property (
    (respDone && responseType == RESP_LONG136)
      |=> state_reg.respWord[2] == $past(respBits[3*WORD_W-1:2*WORD_W])
  ) else $error("long response high word mapped wrongly");

  resp_read_only_a: assert property (
    respWrite |=> $stable(state_reg.respWord)
  ) else $error("response word changed on a software write");

  resp_reset_zero_a: assert property (
    $fell(rst) |-> (state_reg.respWord == '0)
  ) else $error("response words not zero after reset");

  rtype_follows_a: assert property (
    cmdWrite |=> responseType == $past(accWdata[RTYPE_LSB +: 2])
  ) else $error("response type did not follow the command write");

  no_resp_keeps_a: assert property (
    (respDone && responseType == RESP_NONE && !accWr)
      |=> $stable(state_reg.respWord)
  ) else $error("response words changed for a command without response");

endmodule // sdcr_cmd_resp_regs

// ===== verification/sdcr_card_model.sv
`timescale 1ns/100ps
// card side: answers commands and moves blocks
module sdcr_card_model
  import sdcr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  cmdIssue,
  input  wire sdcr_resp_type_t       responseType,
  input  wire logic                  xferActive,
  input  wire logic [RESP_W-1:0]     pattern,
  input  wire logic                  spurious,
  input  wire logic [7:0]            gap,
  output logic                       respDone,
  output logic [RESP_W-1:0]          respBits,
  output logic                       blockDone
);
  logic       pend;
  logic [7:0] dly;
  logic [7:0] bcnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {respDone, blockDone, pend} <= 3'h0;
      {dly, bcnt} <= 16'h0000;
      respBits <= '0;
    end else begin
      respDone <= 1'b0;
      blockDone <= 1'b0;
      // bits are only valid with the pulse; scramble so a late sample is caught
      if (respDone) respBits <= ~respBits;
      // spurious stands for a faulty engine pulsing with no answer expected
      if (cmdIssue && (responseType != RESP_NONE || spurious)) begin
        pend <= 1'b1;
        dly <= gap;
      end else if (pend) begin
        if (dly == 8'h00) begin
          pend <= 1'b0;
          respDone <= 1'b1;
          respBits <= pattern;
        end else dly <= dly - 8'h01;
      end
      if (xferActive && !blockDone) begin
        if (bcnt >= gap) begin
          blockDone <= 1'b1;
          bcnt <= 8'h00;
        end else bcnt <= bcnt + 8'h01;
      end else bcnt <= 8'h00;
    end
  end
endmodule // sdcr_card_model

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import sdcr_pkg::*;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, xferStart, xferStop, spurious;
  logic cmdIssue, transferDirection, dmaModeEnable, multiBlockSelect, blockCountEnable;
  logic xferActive, xferEnd, respDone, blockDone;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [7:0]        gap;
  logic [15:0]       blockCount;
  logic [31:0]       haddr, hwdata, hrdata, rdv, blkSeen, mismatches, checkCount;
  logic [RESP_W-1:0] respBits, pattern;
  sdcr_resp_type_t   responseType;
  sdcr_cmd_resp_regs u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .respDone(respDone),
    .respBits(respBits), .xferStart(xferStart), .blockDone(blockDone), .xferStop(xferStop),
    .cmdIssue(cmdIssue), .responseType(responseType), .transferDirection(transferDirection),
    .dmaModeEnable(dmaModeEnable), .multiBlockSelect(multiBlockSelect),
    .blockCountEnable(blockCountEnable), .blockCount(blockCount), .xferActive(xferActive),
    .xferEnd(xferEnd));
  sdcr_card_model u_card (.clk(clk), .rst(rst), .cmdIssue(cmdIssue),
    .responseType(responseType), .xferActive(xferActive), .pattern(pattern),
    .spurious(spurious), .gap(gap), .respDone(respDone), .respBits(respBits),
    .blockDone(blockDone));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // running total of blocks moved; scenarios take differences
  always @(posedge clk or posedge rst) begin
    if (rst) blkSeen <= 32'h0;
    else if (blockDone === 1'b1 && xferActive === 1'b1) blkSeen <= blkSeen + 32'h1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one transfer of size sz; hready is judged as it stood at the edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [2:0] sz);
    logic r;
    int   n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= w;
    hsize <= sz;
    n = 0;
    do begin @(negedge clk); r = hreadyout; @(posedge clk); n++; end while (r !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(negedge clk);
      r = hreadyout;
      rdv = hrdata;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "bus hang");
    chk({31'h0, hresp}, 32'h0, "response not OKAY");
    hsel <= 1'b0;
    @(negedge clk);
  endtask
  task automatic pulse(input logic stopIt);
    @(posedge clk);
    if (stopIt) xferStop <= 1'b1;
    else xferStart <= 1'b1;
    @(posedge clk);
    {xferStart, xferStop} <= 2'h0;
  endtask
  task automatic wait_on(input logic which);
    int n;
    n = 0;
    do begin @(negedge clk); n++; end
    while ((which ? xferEnd : respDone) !== 1'b1 && n < 2000);
    chk({31'h0, n < 2000}, 32'h1, "no completion");
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, RESP_WORD0_OFS + 12'(4 * i), 32'h0, HSIZE_WORD);
      chk(rdv, RESP_RESET, "response word after reset");
    end
  endtask
  task automatic test_fields();
    logic [1:0]  t;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      t = 2'(i);
      v = {14'h0000, t, 10'h000, 1'b0, t[0], 2'h0, t[1], t[1]};
      bus(1'b1, COMMAND_CONTROL_OFS, v | 32'hFFFC_FFCC, HSIZE_WORD);
      chk({31'h0, transferDirection}, {31'h0, t[0]}, "direction");
      chk({31'h0, dmaModeEnable}, {31'h0, t[1]}, "dma enable");
      chk({30'h0, responseType}, {30'h0, t}, "response type");
      chk({30'h0, multiBlockSelect, blockCountEnable}, {31'h0, t[1]}, "multi and count");
      bus(1'b0, COMMAND_CONTROL_OFS, 32'h0, HSIZE_WORD);
      chk(rdv, v, "command readback");
    end
  endtask
  task automatic capture(input logic [1:0] t, input logic [RESP_W-1:0] p,
                         input logic [95:0] exp);
    pattern = p;
    bus(1'b1, COMMAND_CONTROL_OFS, {14'h0000, t, 16'h0000}, HSIZE_WORD);
    wait_on(1'b0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, RESP_WORD0_OFS + 12'(4 * i), 32'h0, HSIZE_WORD);
      chk(rdv, exp[32*i +: 32], "response word");
    end
  endtask
  task automatic test_responses();
    logic [127:0] pl, ps;
    pl = 128'hFEDC_BA98_7654_3210_0F1E_2D3C_4B5A_6978;
    ps = 128'h1357_9BDF_2468_ACE0_5A5A_C3C3_A5A5_3C3C;
    capture(2'h1, pl, pl[95:0]);
    capture(2'h2, ps, {pl[95:32], ps[39:8]});
    capture(2'h3, ~ps, {pl[95:32], ~ps[39:8]});
    spurious = 1'b1;
    capture(2'h0, pl, {pl[95:32], ~ps[39:8]});
    spurious = 1'b0;
    bus(1'b1, RESP_WORD0_OFS, 32'h0, HSIZE_WORD);
    bus(1'b0, RESP_WORD0_OFS, 32'h0, HSIZE_WORD);
    chk(rdv, ~ps[39:8], "read-only word written");
    bus(1'b0, 12'h3F0, 32'hFFFF_FFFF, HSIZE_WORD);
    chk(rdv, 32'h0, "unmapped read");
    bus(1'b1, COMMAND_CONTROL_OFS, 32'h0000_0011, 3'h0);
    chk({31'h0, transferDirection}, 32'h0, "byte write refused");
  endtask
  // reset in mid-run must clear captured response words
  task automatic test_midreset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_reset();
  endtask
  task automatic run_xfer(input logic [15:0] nb, input logic ms, input logic bc,
                          input logic [7:0] g, input logic [31:0] expBlk);
    logic [31:0] base;
    bus(1'b1, BLOCK_CONFIG_OFS, {nb, 16'h0000}, HSIZE_WORD);
    bus(1'b1, COMMAND_CONTROL_OFS, {26'h0, ms, 3'h2, bc, 1'b0}, HSIZE_WORD);
    chk({16'h0, blockCount}, {16'h0, nb}, "block count field");
    chk({30'h0, multiBlockSelect, blockCountEnable}, {30'h0, ms, bc}, "multi and count");
    gap <= g;
    base = blkSeen;
    pulse(1'b0);
    if (ms && !bc) begin
      for (int n = 0; n < 500 && (blkSeen - base) < 32'h5; n++) @(negedge clk);
      bus(1'b0, XFER_STATUS_OFS, 32'h0, HSIZE_WORD);
      chk({30'h0, rdv[1:0]}, 32'h3, "open-ended still active");
      pulse(1'b1);
    end
    wait_on(1'b1);
    if (bc || !ms) chk(blkSeen - base, expBlk, "blocks moved");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, hsel, hwrite, xferStart, xferStop, spurious} = 6'h20;
    {htrans, hsize, haddr, hwdata, mismatches, checkCount} = '0;
    gap = 8'h02;
    pattern = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_fields();
    test_responses();
    test_midreset();
    run_xfer(16'h0003, 1'b1, 1'b1, 8'h01, 32'h3);
    run_xfer(16'h0003, 1'b1, 1'b1, 8'h09, 32'h3);
    run_xfer(16'h0000, 1'b1, 1'b1, 8'h01, 32'h0);
    run_xfer(16'h0005, 1'b0, 1'b1, 8'h01, 32'h1);
    run_xfer(16'h0002, 1'b1, 1'b0, 8'h03, 32'h0);
    print_verdict();
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule // testbench
